// ===== common/lsp_pkg.sv
// constants and types shared by the serial write port of the led driver
package lsp_pkg;
  localparam int unsigned BYTE_WIDTH = 8;
  localparam int unsigned STRAP_WIDTH = 5;
  localparam int unsigned CFG_WIDTH = STRAP_WIDTH + 1;
  // nine ones followed by a zero gap, oldest bit on the left
  localparam logic [9:0] START_PATTERN = 10'h3fe;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] GAP_SLOT = 4'h8;
  localparam logic [3:0] BIT_INDEX_FIRST = 4'h0;
  localparam logic [3:0] BIT_INDEX_STEP = 4'h1;
  localparam logic ID_TOP_VALUE = 1'h1;
  localparam logic ID_SECOND_VALUE = 1'h0;
  localparam int unsigned ID_TOP_POS = 7;
  localparam int unsigned ID_SECOND_POS = 6;
  localparam int unsigned ID_STRAP_HI = 5;
  localparam int unsigned ID_STRAP_LO = 1;
  localparam logic [7:0] REG_ADDR_LAST = 8'h1f;
  localparam logic [7:0] REG_ADDR_FIRST = 8'h00;
  localparam logic [7:0] REG_ADDR_STEP = 8'h01;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [4:0] {
    LSP_HUNT = 5'h01,
    LSP_TARGET = 5'h02,
    LSP_REGADDR = 5'h04,
    LSP_DATA = 5'h08,
    LSP_SKIP = 5'h10
  } lsp_link_state_type;
endpackage

// ===== common/lsp_wr_if.sv
// write event carried from the serial-clock logic to the system clock side
`timescale 1ns/1ps
`default_nettype none
interface lsp_wr_if;
  logic toggle;
  logic [7:0] addr;
  logic [7:0] data;
  modport src (output toggle, output addr, output data);
  modport dst (input toggle, input addr, input data);
endinterface
`default_nettype wire

// ===== design/lsp_sync.sv
// two flip-flop level synchroniser for a group of slow or static inputs
`timescale 1ns/1ps
`default_nettype none
module lsp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // first stage feeds only the second one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // lsp_sync
`default_nettype wire

// ===== design/lsp_write_cdc.sv
// system side of the write event crossing: toggle sync and word capture
`timescale 1ns/1ps
`default_nettype none
module lsp_write_cdc (
  input wire logic clock,
  input wire logic rst_n,
  lsp_wr_if.dst link,
  output logic write_strobe,
  output logic [7:0] write_addr,
  output logic [7:0] write_data
);
  logic toggle_sync;
  logic toggle_seen;

  lsp_sync #(.WIDTH(1)) u_toggle_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(link.toggle),
    .sync_out(toggle_sync)
  );

  // one pulse per toggle; the word is stable for many serial clocks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      toggle_seen <= 1'h0;
      write_strobe <= 1'h0;
      write_addr <= lsp_pkg::BYTE_RESET;
      write_data <= lsp_pkg::BYTE_RESET;
    end else begin
      toggle_seen <= toggle_sync;
      write_strobe <= toggle_sync ^ toggle_seen;
      if (toggle_sync ^ toggle_seen) begin
        write_addr <= link.addr;
        write_data <= link.data;
      end
    end
  end
endmodule // lsp_write_cdc
`default_nettype wire

// ===== design/lsp_write_port.sv
// serial write port: two-wire and three-wire frame decoder with write output
`timescale 1ns/1ps
`default_nettype none
module lsp_write_port (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic serial_data_pin,
  input wire logic frame_enable_pin,
  input wire logic two_wire_mode_pin,
  input wire logic [4:0] id_strap_pins,
  output logic reg_write_strobe,
  output logic [7:0] reg_write_addr,
  output logic [7:0] reg_write_data
);
  logic [lsp_pkg::CFG_WIDTH-1:0] cfg_sync;
  logic two_wire;
  logic [lsp_pkg::STRAP_WIDTH-1:0] strap;
  logic frame_clear_n;
  logic [8:0] history;
  logic [7:0] shift;
  logic [3:0] bit_idx;
  logic [7:0] reg_addr;
  lsp_pkg::lsp_link_state_type state;
  lsp_pkg::lsp_link_state_type cur_state;
  lsp_pkg::lsp_link_state_type next_state;
  logic receiving;
  logic start_seen;
  logic byte_done;
  logic [7:0] byte_value;
  logic id_match;
  logic gap_slot;
  logic [3:0] next_bit_idx;
  logic [7:0] next_reg_addr;

  lsp_wr_if wr_link ();

  // straps and mode are static pins, so resync them on the link clock
  lsp_sync #(.WIDTH(lsp_pkg::CFG_WIDTH)) u_cfg_sync (
    .clock(serial_clock),
    .rst_n(rst_n),
    .async_in({two_wire_mode_pin, id_strap_pins}),
    .sync_out(cfg_sync)
  );
  assign two_wire = cfg_sync[lsp_pkg::STRAP_WIDTH];
  assign strap = cfg_sync[lsp_pkg::STRAP_WIDTH-1:0];

  // in three-wire mode the enable's low level ends the frame, even if
  // the serial clock has already stopped; two-wire frames end on gaps
  assign frame_clear_n = rst_n & (two_wire | frame_enable_pin);

  // three-wire frames start straight at the target id byte
  assign cur_state = (!two_wire && state == lsp_pkg::LSP_HUNT) ?
                     lsp_pkg::LSP_TARGET : state;
  assign receiving = (cur_state == lsp_pkg::LSP_TARGET) ||
                     (cur_state == lsp_pkg::LSP_REGADDR) ||
                     (cur_state == lsp_pkg::LSP_DATA);
  assign start_seen = two_wire &&
                      ({history, serial_data_pin} == lsp_pkg::START_PATTERN);
  assign gap_slot = two_wire && (bit_idx == lsp_pkg::GAP_SLOT);

  // id byte check: fixed top two bits, straps below, lowest bit free
  assign id_match = (byte_value[lsp_pkg::ID_TOP_POS] == lsp_pkg::ID_TOP_VALUE) &&
                    (byte_value[lsp_pkg::ID_SECOND_POS] == lsp_pkg::ID_SECOND_VALUE) &&
                    (byte_value[lsp_pkg::ID_STRAP_HI:lsp_pkg::ID_STRAP_LO] == strap);

  // byte completion and frame sequencing
  always_comb begin
    next_state = state;
    byte_done = 1'h0;
    byte_value = shift;
    if (two_wire) begin
      if (start_seen) begin
        next_state = lsp_pkg::LSP_TARGET;
      end else if (receiving && gap_slot) begin
        if (serial_data_pin) begin
          next_state = lsp_pkg::LSP_HUNT;
        end else begin
          byte_done = 1'h1;
        end
      end
    end else begin
      byte_value = {shift[6:0], serial_data_pin};
      byte_done = receiving && (bit_idx == lsp_pkg::LAST_DATA_BIT);
    end
    if (byte_done && !start_seen) begin
      case (cur_state)
        lsp_pkg::LSP_TARGET: begin
          next_state = id_match ? lsp_pkg::LSP_REGADDR : lsp_pkg::LSP_SKIP;
        end
        lsp_pkg::LSP_REGADDR: begin
          next_state = lsp_pkg::LSP_DATA;
        end
        lsp_pkg::LSP_DATA: begin
          next_state = lsp_pkg::LSP_DATA;
        end
        default: begin
          next_state = cur_state;
        end
      endcase
    end
  end

  // bit position within the current byte, gap slot included in two-wire
  always_comb begin
    next_bit_idx = bit_idx;
    if (start_seen) begin
      next_bit_idx = lsp_pkg::BIT_INDEX_FIRST;
    end else if (!receiving) begin
      next_bit_idx = lsp_pkg::BIT_INDEX_FIRST;
    end else if (gap_slot || (!two_wire && bit_idx == lsp_pkg::LAST_DATA_BIT)) begin
      next_bit_idx = lsp_pkg::BIT_INDEX_FIRST;
    end else begin
      next_bit_idx = bit_idx + lsp_pkg::BIT_INDEX_STEP;
    end
  end

  // register address: loaded by the second byte, stepped after each data byte
  always_comb begin
    next_reg_addr = reg_addr;
    if (byte_done && !start_seen && cur_state == lsp_pkg::LSP_REGADDR) begin
      next_reg_addr = byte_value;
    end else if (byte_done && !start_seen && cur_state == lsp_pkg::LSP_DATA) begin
      if (reg_addr == lsp_pkg::REG_ADDR_LAST) begin
        next_reg_addr = lsp_pkg::REG_ADDR_FIRST;
      end else begin
        next_reg_addr = reg_addr + lsp_pkg::REG_ADDR_STEP;
      end
    end
  end

  // start pattern history, kept across frames so a start is seen anywhere
  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      history <= '0;
    end else begin
      history <= {history[7:0], serial_data_pin};
    end
  end

  // data shift register, msb first; gap bits are not shifted in
  always_ff @(posedge serial_clock or negedge frame_clear_n) begin
    if (!frame_clear_n) begin
      shift <= lsp_pkg::BYTE_RESET;
    end else if (!gap_slot) begin
      shift <= {shift[6:0], serial_data_pin};
    end
  end

  // bit counter
  always_ff @(posedge serial_clock or negedge frame_clear_n) begin
    if (!frame_clear_n) begin
      bit_idx <= lsp_pkg::BIT_INDEX_FIRST;
    end else begin
      bit_idx <= next_bit_idx;
    end
  end

  // frame state
  always_ff @(posedge serial_clock or negedge frame_clear_n) begin
    if (!frame_clear_n) begin
      state <= lsp_pkg::LSP_HUNT;
    end else begin
      state <= next_state;
    end
  end

  // register address pointer
  always_ff @(posedge serial_clock or negedge frame_clear_n) begin
    if (!frame_clear_n) begin
      reg_addr <= lsp_pkg::REG_ADDR_FIRST;
    end else begin
      reg_addr <= next_reg_addr;
    end
  end

  // write event: word held still and a toggle flipped; the toggle only
  // sees the full reset, so ending a frame never fakes an event
  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_link.toggle <= 1'h0;
      wr_link.addr <= lsp_pkg::BYTE_RESET;
      wr_link.data <= lsp_pkg::BYTE_RESET;
    end else if (byte_done && !start_seen && cur_state == lsp_pkg::LSP_DATA) begin
      wr_link.toggle <= ~wr_link.toggle;
      wr_link.addr <= reg_addr;
      wr_link.data <= byte_value;
    end
  end

  // writes surface on the system clock as a one-cycle strobe
  lsp_write_cdc u_write_cdc (
    .clock(clock),
    .rst_n(rst_n),
    .link(wr_link),
    .write_strobe(reg_write_strobe),
    .write_addr(reg_write_addr),
    .write_data(reg_write_data)
  );
endmodule // lsp_write_port
`default_nettype wire

// ===== testbench/lsp_write_port_chk.sv
// port assertions for the serial write port
`timescale 1ns/1ps
`default_nettype none
module lsp_write_port_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic serial_data_pin,
  input wire logic frame_enable_pin,
  input wire logic two_wire_mode_pin,
  input wire logic [4:0] id_strap_pins,
  input wire logic reg_write_strobe,
  input wire logic [7:0] reg_write_addr,
  input wire logic [7:0] reg_write_data
);
  logic [7:0] edges;
  logic [7:0] prev_addr;
  logic same_win;
  logic [5:0] low_cnt;
  // link edges in this enable window; cleared async as the clock may stop
  always_ff @(posedge serial_clock or negedge frame_enable_pin or negedge rst_n) begin
    if (!rst_n || !frame_enable_pin) edges <= 8'h00;
    else edges <= edges + 8'h01;
  end
  // enable low time, saturating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) low_cnt <= 6'h00;
    else if (frame_enable_pin) low_cnt <= 6'h00;
    else if (low_cnt != 6'h3f) low_cnt <= low_cnt + 6'h01;
  end
  // last write address; a long enable low closes the window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_addr <= 8'h00;
      same_win <= 1'b0;
    end else if (reg_write_strobe) begin
      prev_addr <= reg_write_addr;
      same_win <= 1'b1;
    end else if (low_cnt == 6'h3f) same_win <= 1'b0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_write; reg_write_strobe; endsequence
  sequence s_quiet; !reg_write_strobe [*8]; endsequence
  strobe_spacing_a: assert property (s_write |=> s_quiet)
    else $error("strobe too long");
  addr_hold_a: assert property (!$stable(reg_write_addr) |-> s_write)
    else $error("addr moved");
  data_hold_a: assert property (!$stable(reg_write_data) |-> s_write)
    else $error("data moved");
  reset_quiet_a: assert property ($rose(rst_n) |-> !reg_write_strobe ##1 !reg_write_strobe)
    else $error("write after reset");
  full_frame_a: assert property (s_write ##0 !two_wire_mode_pin |-> edges >= 8'h18)
    else $error("short frame wrote");
  byte_align_a: assert property (s_write ##0 !two_wire_mode_pin |-> edges[2:0] <= 3'h4)
    else $error("write off byte");
  enable_window_a: assert property (s_write ##0 !two_wire_mode_pin |-> low_cnt == 6'h00)
    else $error("write outside enable");
  addr_step_a: assert property (s_write ##0 same_win && !two_wire_mode_pin |->
    reg_write_addr == ((prev_addr == 8'h1f) ? 8'h00 : prev_addr + 8'h01)) else $error("bad step");
endmodule // lsp_write_port_chk
bind lsp_write_port lsp_write_port_chk i_lsp_write_port_chk (.clock, .rst_n, .serial_clock,
  .serial_data_pin, .frame_enable_pin, .two_wire_mode_pin, .id_strap_pins, .reg_write_strobe,
  .reg_write_addr, .reg_write_data);
`default_nettype wire

// ===== testbench/lsp_host.sv
// host model driving the serial link; its clock runs only within frames and idle pulses
`timescale 1ns/1ps
`default_nettype none
module lsp_host (
  output var logic serial_clock,
  output var logic serial_data_pin,
  output var logic frame_enable_pin
);
  initial begin
    serial_clock = 1'b0;
    serial_data_pin = 1'b0;
    frame_enable_pin = 1'b0;
  end
  // one 15 ns pulse, data set up on the low phase
  task automatic pulse();
    #7.5 serial_clock = 1'b1;
    #7.5 serial_clock = 1'b0;
  endtask
  // idle pulses with data and enable low so mode and straps settle
  task automatic idle(input int k);
    serial_data_pin = 1'b0;
    repeat (k) pulse();
  endtask
  // random phase; after the hold time data no longer shows the last bit
  task automatic send(input logic [127:0] bits, input int n, input logic use_en);
    #($urandom_range(40, 1));
    frame_enable_pin = use_en;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_pin = bits[i];
      pulse();
    end
    #200 frame_enable_pin = 1'b0;
    serial_data_pin = ~serial_data_pin;
    #1000;
  endtask
endmodule // lsp_host
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the serial write port
`timescale 1ns/1ps
`default_nettype none
`define LSP_CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic two_wire_mode_pin = 1'b0;
  logic [4:0] id_strap_pins = 5'h00;
  logic serial_clock, serial_data_pin, frame_enable_pin, reg_write_strobe;
  logic [7:0] reg_write_addr, reg_write_data;
  int miscompares = 0;
  int checked = 0;
  logic [15:0] expect_q[$];
  logic [15:0] w;
  logic [127:0] fr;
  int fn;
  always #4 clock = ~clock;
  lsp_host i_lsp_host (.serial_clock, .serial_data_pin, .frame_enable_pin);
  lsp_write_port i_lsp_write_port (.clock, .rst_n, .serial_clock, .serial_data_pin,
    .frame_enable_pin, .two_wire_mode_pin, .id_strap_pins, .reg_write_strobe,
    .reg_write_addr, .reg_write_data);
  // every write must match the oldest noted one; looked at mid-cycle so the
  // strobe and its word are settled, never in the edge that launches them
  always @(negedge clock) begin
    if (reg_write_strobe === 1'b1) begin
      if (expect_q.size() == 0) `LSP_CHECK(reg_write_strobe, 1'b0)
      else begin
        w = expect_q.pop_front();
        `LSP_CHECK({reg_write_addr, reg_write_data}, w)
      end
    end
  end
  function automatic logic [7:0] own_id();
    return {2'b10, id_strap_pins, 1'($urandom)};
  endfunction
  task automatic put(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      fr = {fr[126:0], b[i]};
      fn++;
    end
  endtask
  // appends a frame; bad names the byte whose gap is one
  task automatic wr(input logic [7:0] idb, input logic [7:0] a, input int nd, input int tail,
      input int bad);
    logic [7:0] d;
    int g;
    logic hit;
    g = int'(two_wire_mode_pin);
    hit = (idb[7:1] == {2'b10, id_strap_pins});
    put(8'hff, 8 * g);
    put(8'h80, g);
    put(8'h00, g);
    put(idb, 8);
    put({bad == 0, 7'h00}, g);
    put(a, 8);
    put({bad == 1, 7'h00}, g);
    for (int k = 0; k < nd; k++) begin
      d = 8'($urandom);
      put(d, 8);
      put({bad == k + 2, 7'h00}, g);
      if (hit && k + 2 < bad) expect_q.push_back({a, d});
      a = (a == 8'h1f) ? 8'h00 : a + 8'h01;
    end
    put(8'($urandom), tail);
  endtask
  task automatic go(input logic [7:0] idb, input logic [7:0] a, input int nd, input int tail,
      input int bad);
    fn = 0;
    wr(idb, a, nd, tail, bad);
    i_lsp_host.send(fr, fn, !two_wire_mode_pin || 1'($urandom));
  endtask
  // reset also spans link edges; mode and straps change only here
  task automatic restart(input logic mode);
    @(negedge clock);
    rst_n = 1'b0;
    two_wire_mode_pin = mode;
    id_strap_pins = 5'($urandom);
    i_lsp_host.idle(2);
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    i_lsp_host.idle(4);
  endtask
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h9744));
    for (int m = 0; m < 2; m++) begin
      restart(m[0]);
      go(own_id(), 8'($urandom_range(31)), 1, 0, 9);
      go(own_id(), 8'h1e, 3, 5, 9);
      go(own_id(), 8'($urandom), 0, 7 + m, 9);
      go(own_id() ^ 8'h40, 8'h02, 2, 0, 9);
      go(own_id() ^ 8'h08, 8'h02, 2, 0, 9);
    end
    fn = 0;
    wr(own_id(), 8'h05, 2, 0, 1);
    wr(own_id(), 8'h07, 1, 0, 9);
    i_lsp_host.send(fr, fn, 1'b0);
    go(own_id(), 8'h10, 2, 0, 2);
    fn = 0;
    put(own_id(), 8);
    put(8'h1f, 6);
    wr(own_id(), 8'h09, 1, 0, 9);
    i_lsp_host.send(fr, fn, 1'b1);
    for (int t = 0; t < 100 && expect_q.size() != 0; t++) @(posedge clock);
    `LSP_CHECK(expect_q.size(), 0)
    end_sim();
  end
  // hang guard, about four times the expected run
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
